// >>> sad_regs.svh
`ifndef SAD_REGS_SVH
`define SAD_REGS_SVH

// Processor physical address width
`define SAD_ADDR_W 34
// Start of the memory mapped I/O space (upper 10 GB)
`define SAD_IO_BASE 34'h1_8000_0000
// Primary PCI dense memory window
`define SAD_P0_DMEM_BASE 34'h1_8000_0000
`define SAD_P0_DMEM_LAST 34'h1_FFFF_FFFF
// Primary PCI sparse memory window
`define SAD_P0_SMEM_BASE 34'h2_0000_0000
`define SAD_P0_SMEM_LAST 34'h2_FFFF_FFFF
// Primary PCI configuration window
`define SAD_P0_CFG_BASE 34'h3_0000_0000
`define SAD_P0_CFG_LAST 34'h3_7FFF_FFFF
// Local system bus CSR window, sixteen 16 MB node slots
`define SAD_CSR_BASE 34'h3_8000_0000
`define SAD_CSR_LAST 34'h3_8FFF_FFFF
// Primary PCI sparse I/O window
`define SAD_P0_SIO_BASE 34'h3_A000_0000
`define SAD_P0_SIO_LAST 34'h3_BFFF_FFFF
// Optional secondary wide PCI window
`define SAD_P1_BASE 34'h3_C000_0000
`define SAD_P1_LAST 34'h3_FFFF_FFFF
// Sparse spaces carry five low address bits of length encoding
`define SAD_SPARSE_SHIFT 5
// Node slot field position and populated slots
`define SAD_CSR_SLOT_LSB 24
`define SAD_CSR_SLOT_MASK 16'hCF0F
// Bridge to the expansion bus answers the lowest 64 KB of sparse I/O
`define SAD_EISA_LIMIT 32'h0001_0000
// Cacheable quadrant number
`define SAD_CACHED_QUAD 2'h0

`endif

// >>> sad_pkg.sv
package sad_pkg;

  // Where a reference is sent
  typedef enum logic [5:0] {
    SAD_TGT_NONE = 6'h01,
    SAD_TGT_MEM = 6'h02,
    SAD_TGT_CSR = 6'h04,
    SAD_TGT_PRI_PCI = 6'h08,
    SAD_TGT_EISA = 6'h10,
    SAD_TGT_WIDE_PCI = 6'h20
  } sad_target_e;

  // Which primary PCI address space a remote reference uses
  typedef enum logic [4:0] {
    SAD_PSP_NONE = 5'h01,
    SAD_PSP_DMEM = 5'h02,
    SAD_PSP_SMEM = 5'h04,
    SAD_PSP_SIO = 5'h08,
    SAD_PSP_CFG = 5'h10
  } sad_pci_space_e;

  typedef struct packed {
    logic [33:0] addr;
    logic write;
  } sad_req_s;

  typedef struct packed {
    sad_target_e target;
    sad_pci_space_e pci_space;
    logic io_space;
    logic cached;
    logic [1:0] quadrant;
    logic [3:0] csr_node;
    logic csr_reserved;
    logic bios_timer_hit;
    logic unmapped;
    logic write;
    logic [33:0] target_addr;
  } sad_rsp_s;

endpackage

// >>> sad_pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output follows once stages two and three agree
module sad_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pin side and synchronised side
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Agreement filter rejects a single-cycle glitch past the metastable stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= '0;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// >>> sad_decoder.sv
// Contract
// - Each 34-bit processor address is classed as memory space or I/O space.
// - Memory is split into four equal quadrants and only quadrant zero is cacheable.
// - The top ten gigabytes are memory mapped I/O, cut into subspaces of their own kind.
// - Every I/O reference goes either to a local system bus CSR or to a remote bus; holes, unpopulated node slots and an absent wide bus get no target.
// - The always present primary 32-bit PCI bus has its own I/O regions.
// - Expansion bus references are sent through the bridge on the primary PCI bus.
// - The expansion bus answers the lowest 64 KB of primary PCI sparse I/O space.
// - The optional secondary 64-bit PCI region decodes only when that bus is fitted.
// - CSR space starts at 3.8000.0000 with 16 MB slots for CPUs, memories and I/O nodes.
// - CSR accesses follow the system bus local CSR protocol and each node keeps it.
// - The bridge BIOS timer is reached only from the PCI side at its configured base.
`timescale 1ns/1ps
`include "sad_regs.svh"
module sad_decoder
  import sad_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  // Processor request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire sad_req_s REQ,
  // Decoded reference towards the targets
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output sad_rsp_s RSP,
  // System configuration
  input wire logic WIDE_PCI_PRESENT,
  input wire logic BIOS_TIMER_EN,
  input wire logic [31:0] BIOS_TIMER_BASE_CONFIG
);

  logic wide_pci_fitted;
  logic take;
  logic rsp_valid_q;
  logic rsp_valid_d;
  sad_rsp_s rsp_q;
  sad_rsp_s rsp_d;
  // Window hits and the sparse I/O side decodes
  logic io_hit;
  logic dmem_hit;
  logic smem_hit;
  logic cfg_hit;
  logic csr_hit;
  logic sio_hit;
  logic wide_hit;
  logic [3:0] csr_slot;
  logic slot_populated;
  logic [33:0] sio_off;
  logic [31:0] sio_pci_addr;
  logic timer_hit;
  logic eisa_hit;

  // The decode is combinational from the request and lands in one register stage,
  // so every answer follows its take by exactly one cycle. Sparse length bits are
  // shifted out and never checked; byte lane handling belongs to the bridges.

  // Populated node slots, one bit per 16 MB slot; slots 4 to 7, 12 and 13 stay clear
  localparam logic [15:0] populated_slots = `SAD_CSR_SLOT_MASK;

  // Presence strap arrives from a backplane pin, so it is synchronised
  // Four enabled edges pass before a strap change reaches the decode
  sad_pin_sync #(
    .WIDTH(1)
  ) u_present_sync (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .ce(CE),
    .pin(WIDE_PCI_PRESENT),
    .level(wide_pci_fitted)
  );

  // One-deep pipeline; a stalled answer holds the next request off
  // CE low drops ready at once, so nothing is taken while state is frozen
  assign REQ_READY = CE && (!rsp_valid_q || RSP_READY);
  assign take = REQ_VALID && REQ_READY;
  assign RSP_VALID = rsp_valid_q;
  assign RSP = rsp_q;

  // I/O subspaces
  // Window hits; io_hit covers all the others, which are disjoint, so at most one of them is set for any address
  assign io_hit = (REQ.addr >= `SAD_IO_BASE);
  assign dmem_hit = io_hit && (REQ.addr <= `SAD_P0_DMEM_LAST);
  assign smem_hit = (REQ.addr >= `SAD_P0_SMEM_BASE) && (REQ.addr <= `SAD_P0_SMEM_LAST);
  assign cfg_hit = (REQ.addr >= `SAD_P0_CFG_BASE) && (REQ.addr <= `SAD_P0_CFG_LAST);
  assign csr_hit = (REQ.addr >= `SAD_CSR_BASE) && (REQ.addr <= `SAD_CSR_LAST);
  assign sio_hit = (REQ.addr >= `SAD_P0_SIO_BASE) && (REQ.addr <= `SAD_P0_SIO_LAST);
  assign wide_hit = (REQ.addr >= `SAD_P1_BASE);

  // node slot decode
  // Slot lookup by table, so a board with other populated slots only edits the mask
  assign csr_slot = REQ.addr[`SAD_CSR_SLOT_LSB +: 4];
  assign slot_populated = populated_slots[csr_slot];

  // Sparse I/O address; the low five bits carry length and byte lanes and are dropped
  assign sio_off = REQ.addr - `SAD_P0_SIO_BASE;
  assign sio_pci_addr = {8'h00, sio_off[28:`SAD_SPARSE_SHIFT]};
  // timer seen only as a PCI target
  // Only the longword address is compared; the timer is one 32-bit register
  assign timer_hit = BIOS_TIMER_EN && (sio_pci_addr[31:2] == BIOS_TIMER_BASE_CONFIG[31:2]);
  // lowest 64 KB goes to the bridge
  // A timer match wins over the bridge window, since the bridge side never sees the timer
  assign eisa_hit = (sio_pci_addr < `SAD_EISA_LIMIT) && !timer_hit;

  // Address decode of the request
  always_comb begin
    logic [33:0] off;
    logic [31:0] pci_addr;
    off = '0;
    pci_addr = '0;
    rsp_d = '0;
    rsp_d.target = SAD_TGT_NONE;
    rsp_d.pci_space = SAD_PSP_NONE;
    rsp_d.write = REQ.write;
    rsp_d.quadrant = REQ.addr[33:32];
    rsp_d.io_space = io_hit;
    if (!io_hit) begin
      // quadrant cacheability
      // Quadrant one shares its upper part with I/O space; I/O decode wins there
      rsp_d.target = SAD_TGT_MEM;
      rsp_d.cached = (REQ.addr[33:32] == `SAD_CACHED_QUAD);
      rsp_d.target_addr = REQ.addr;
    end else if (dmem_hit) begin
      // primary PCI dense memory
      // Dense space passes the offset straight through; no length bits
      off = REQ.addr - `SAD_P0_DMEM_BASE;
      rsp_d.target = SAD_TGT_PRI_PCI;
      rsp_d.pci_space = SAD_PSP_DMEM;
      rsp_d.target_addr = {2'h0, off[31:0]};
    end else if (smem_hit) begin
      // primary PCI sparse memory
      // Sparse memory drops the five length bits
      off = REQ.addr - `SAD_P0_SMEM_BASE;
      pci_addr = {5'h00, off[31:`SAD_SPARSE_SHIFT]};
      rsp_d.target = SAD_TGT_PRI_PCI;
      rsp_d.pci_space = SAD_PSP_SMEM;
      rsp_d.target_addr = {2'h0, pci_addr};
    end else if (cfg_hit) begin
      // primary PCI configuration
      // Configuration window is half the size, so one bit fewer survives
      off = REQ.addr - `SAD_P0_CFG_BASE;
      pci_addr = {6'h00, off[30:`SAD_SPARSE_SHIFT]};
      rsp_d.target = SAD_TGT_PRI_PCI;
      rsp_d.pci_space = SAD_PSP_CFG;
      rsp_d.target_addr = {2'h0, pci_addr};
    end else if (csr_hit) begin
      // Node number and offset inside the 16 MB slot
      rsp_d.csr_node = csr_slot;
      rsp_d.target_addr = {10'h000, REQ.addr[23:0]};
      if (slot_populated) begin
        rsp_d.target = SAD_TGT_CSR;
      end else begin
        rsp_d.target = SAD_TGT_NONE;
        rsp_d.csr_reserved = 1'b1;
      end
    end else if (sio_hit) begin
      // Primary PCI sparse I/O, shared with the bridge below 64 KB
      rsp_d.pci_space = SAD_PSP_SIO;
      rsp_d.target_addr = {2'h0, sio_pci_addr};
      rsp_d.bios_timer_hit = timer_hit;
      if (eisa_hit) begin
        // through the bridge on the primary bus
        rsp_d.target = SAD_TGT_EISA;
      end else begin
        rsp_d.target = SAD_TGT_PRI_PCI;
      end
    end else if (wide_hit) begin
      // Wide bus window passes its offset straight through
      off = REQ.addr - `SAD_P1_BASE;
      rsp_d.target_addr = {2'h0, off[31:0]};
      // only when the wide bus is fitted
      // An absent bus is flagged rather than dropped, so a probe can fault cleanly
      if (wide_pci_fitted) begin
        rsp_d.target = SAD_TGT_WIDE_PCI;
      end else begin
        rsp_d.unmapped = 1'b1;
      end
    end else begin
      // Hole in the I/O map; flagged so the requester can fault it
      rsp_d.unmapped = 1'b1;
    end
  end

  // Answer valid flag: set on a taken request, cleared once consumed
  always_comb begin
    rsp_valid_d = rsp_valid_q;
    // A take in the same cycle as a consume keeps the flag set
    if (take) begin
      rsp_valid_d = 1'b1;
    end else if (RSP_READY) begin
      rsp_valid_d = 1'b0;
    end
  end

  // Valid flag register; frozen with everything else while CE is low
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rsp_valid_q <= 1'b0;
    end else if (CE) begin
      rsp_valid_q <= rsp_valid_d;
    end
  end

  // Decoded fields are captured only on a taken request, so they hold while stalled
  // Reset answer names no target and no PCI space, matching the idle decode
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rsp_q <= '{target: SAD_TGT_NONE, pci_space: SAD_PSP_NONE, default: '0};
    end else if (CE && take) begin
      rsp_q <= rsp_d;
    end
  end

endmodule

// >>> sad_decoder_checker.sv
`timescale 1ns/1ps
module sad_chk
  import sad_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  // Request and answer
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire sad_req_s REQ,
  input wire logic RSP_VALID,
  input wire logic RSP_READY,
  input wire sad_rsp_s RSP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // Request taken, and answer held back
  sequence s_take;
    CE && REQ_VALID && REQ_READY;
  endsequence
  sequence s_stall;
    RSP_VALID && !(RSP_READY && CE);
  endsequence
  AST_CLASS: assert property (s_take |=> RSP_VALID && RSP.io_space == ($past(REQ.addr) >= 34'h1_8000_0000))
    else $error("space class wrong");
  AST_CACHE: assert property (s_take |=> RSP.cached == ($past(REQ.addr) < 34'h1_8000_0000 && $past(REQ.addr[33:32]) == 2'h0))
    else $error("cached flag wrong");
  AST_IOMAP: assert property (RSP_VALID |-> (RSP.target == SAD_TGT_MEM) == !RSP.io_space)
    else $error("memory target in io space");
  AST_HOLD: assert property (s_stall |=> RSP_VALID && $stable(RSP))
    else $error("answer not held");
  AST_READY: assert property (REQ_READY == (CE && !(RSP_VALID && !RSP_READY)))
    else $error("ready wrong");
  AST_EISA: assert property (RSP_VALID && RSP.target == SAD_TGT_EISA |-> RSP.target_addr < 34'h1_0000)
    else $error("expansion window too wide");
  AST_CSR: assert property (s_take ##0 (REQ.addr[33:28] == 6'h38) |=> RSP.csr_node == $past(REQ.addr[27:24]))
    else $error("node slot wrong");
  AST_RSV: assert property (RSP_VALID && RSP.csr_reserved |-> RSP.target == SAD_TGT_NONE && !RSP.unmapped)
    else $error("reserved slot touched");
  AST_TMR: assert property (RSP_VALID && RSP.bios_timer_hit |-> RSP.target == SAD_TGT_PRI_PCI)
    else $error("timer off primary bus");
endmodule
bind sad_decoder sad_chk u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP_READY(RSP_READY), .RSP(RSP));

// >>> sad_cpu_model.sv
`timescale 1ns/1ps
module sad_cpu
  import sad_pkg::*;
(
  // Clock and handshake
  input wire logic clk,
  input wire logic req_ready,
  output logic req_valid,
  // Reference
  output sad_req_s req
);
  // Idle until the first reference
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic issue(input logic [33:0] a);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{addr: a, write: a[3]};
    while (!req_ready) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    // Inverse after release so a stale address never looks valid
    req.addr = ~req.addr;
  endtask
endmodule

// >>> sad_decoder_tb.sv
`timescale 1ns/1ps
module sad_decoder_tb;
  import sad_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic rsp_ready = 1'b0;
  logic wide = 1'b0;
  logic tmr_en = 1'b0;
  logic ce = 1'b1;
  logic [31:0] tmr_base = 32'h0000_0100;
  logic req_valid, req_ready, rsp_valid;
  sad_req_s req;
  sad_rsp_s rsp;
  int fail_count = 0;
  int tests_run = 0;
  // 250 MHz clock
  always #2 clock = ~clock;
  sad_cpu u_cpu (.clk(clock), .req_ready(req_ready), .req_valid(req_valid), .req(req));
  sad_decoder u_dut (.CLOCK(clock), .RESET_N(reset_n), .CE(ce), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ(req), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP(rsp), .WIDE_PCI_PRESENT(wide),
    .BIOS_TIMER_EN(tmr_en), .BIOS_TIMER_BASE_CONFIG(tmr_base));
  task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Answer is held one extra cycle so the stall path is exercised too
  // Flags are {timer hit, unmapped, reserved slot}; a zero space code skips that compare
  task automatic chk(input logic [33:0] a, input logic [5:0] tgt, input logic c, input logic [33:0] ta,
    input logic [2:0] fl = 3'h0, input logic [4:0] sp = 5'h00);
    u_cpu.issue(a);
    cmp("valid", 34'h1, 34'(rsp_valid));
    cmp("target", 34'(tgt), 34'(rsp.target));
    cmp("cached", 34'(c), 34'(rsp.cached));
    cmp("io_space", 34'(a >= 34'h1_8000_0000), 34'(rsp.io_space));
    cmp("quadrant", 34'(a[33:32]), 34'(rsp.quadrant));
    cmp("write", 34'(a[3]), 34'(rsp.write));
    cmp("timer_hit", 34'(fl[2]), 34'(rsp.bios_timer_hit));
    cmp("unmapped", 34'(fl[1]), 34'(rsp.unmapped));
    cmp("csr_reserved", 34'(fl[0]), 34'(rsp.csr_reserved));
    if (sp != 5'h00) cmp("pci_space", 34'(sp), 34'(rsp.pci_space));
    if (a[33:28] == 6'h38) cmp("csr_node", 34'(a[27:24]), 34'(rsp.csr_node));
    if (tgt != SAD_TGT_NONE) cmp("target_addr", ta, rsp.target_addr);
    @(negedge clock);
    cmp("held", 34'h1, 34'(rsp_valid));
    cmp("stall_ready", 34'h0, 34'(req_ready));
    rsp_ready = 1'b1;
    @(negedge clock);
    cmp("consumed", 34'h0, 34'(rsp_valid));
    rsp_ready = 1'b0;
  endtask
  task automatic t_map;
    chk(34'h0_0000_1000, SAD_TGT_MEM, 1'b1, 34'h0_0000_1000, 3'h0, 5'h01);
    chk(34'h1_0000_0048, SAD_TGT_MEM, 1'b0, 34'h1_0000_0048, 3'h0, 5'h01);
    chk(34'h1_8000_0040, SAD_TGT_PRI_PCI, 1'b0, 34'h40, 3'h0, 5'h02);
    chk(34'h2_0000_0108, SAD_TGT_PRI_PCI, 1'b0, 34'h8, 3'h0, 5'h04);
    chk(34'h3_0000_0200, SAD_TGT_PRI_PCI, 1'b0, 34'h10, 3'h0, 5'h10);
    chk(34'h3_9000_0000, SAD_TGT_NONE, 1'b0, 34'h0, 3'h2, 5'h01);
    chk(34'h3_A01F_FFE0, SAD_TGT_EISA, 1'b0, 34'hFFFF, 3'h0, 5'h08);
    chk(34'h3_A020_0000, SAD_TGT_PRI_PCI, 1'b0, 34'h1_0000, 3'h0, 5'h08);
    $display("t_map done");
  endtask
  // Reserved slots are 4 to 7, 12 and 13
  task automatic t_csr;
    logic [33:0] a;
    logic rsv;
    for (int i = 0; i < 16; i++) begin
      a = 34'h3_8000_0010 | (34'(i) << 24);
      rsv = 1'(16'h30F0 >> i);
      chk(a, rsv ? SAD_TGT_NONE : SAD_TGT_CSR, 1'b0, 34'(a[23:0]), {2'h0, rsv});
    end
    $display("t_csr done");
  endtask
  task automatic t_wide;
    chk(34'h3_C000_0100, SAD_TGT_NONE, 1'b0, 34'h0, 3'h2);
    wide = 1'b1;
    repeat (6) @(negedge clock);
    chk(34'h3_C000_0100, SAD_TGT_WIDE_PCI, 1'b0, 34'h100);
    $display("t_wide done");
  endtask
  task automatic t_tmr;
    tmr_en = 1'b1;
    chk(34'h3_A000_2000, SAD_TGT_PRI_PCI, 1'b0, 34'h100, 3'h4, 5'h08);
    tmr_en = 1'b0;
    chk(34'h3_A000_2000, SAD_TGT_EISA, 1'b0, 34'h100, 3'h0, 5'h08);
    $display("t_tmr done");
  endtask
  // Clock enable low freezes the standing answer and refuses new requests
  task automatic t_freeze;
    u_cpu.issue(34'h0_0000_2000);
    ce = 1'b0;
    rsp_ready = 1'b1;
    repeat (3) @(negedge clock);
    cmp("frozen_ready", 34'h0, 34'(req_ready));
    cmp("frozen_valid", 34'h1, 34'(rsp_valid));
    cmp("frozen_target", 34'(SAD_TGT_MEM), 34'(rsp.target));
    ce = 1'b1;
    @(negedge clock);
    cmp("thawed_valid", 34'h0, 34'(rsp_valid));
    rsp_ready = 1'b0;
    $display("t_freeze done");
  endtask
  task automatic summarize;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    t_map();
    t_csr();
    t_wide();
    t_tmr();
    t_freeze();
    summarize();
  end
  // Watchdog, about eight times the expected run
  initial begin
    #4000;
    fail_count++;
    summarize();
  end
endmodule
